// File: core/rcg_pkg.sv
/*
 * Package for the bus recovery clock block: register map, field layout,
 * result codes, state encodings and the phase timing counts.
 * Assumes a 50 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none

package rcg_pkg;

    // System clock
    localparam int unsigned CLK_HZ = 50_000_000;

    // Minimum recovery clock phase widths, in nanoseconds
    localparam int unsigned FM_LOW_NS = 1300;
    localparam int unsigned FM_HIGH_NS = 600;
    localparam int unsigned SM_LOW_NS = 4700;
    localparam int unsigned SM_HIGH_NS = 4000;

    // Least time rounds up to whole cycles, never below one
    function automatic int unsigned rcg_ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : rcg_ns_to_cyc

    localparam int unsigned FM_LOW_CYC = rcg_ns_to_cyc(FM_LOW_NS);
    localparam int unsigned FM_HIGH_CYC = rcg_ns_to_cyc(FM_HIGH_NS);
    localparam int unsigned SM_LOW_CYC = rcg_ns_to_cyc(SM_LOW_NS);
    localparam int unsigned SM_HIGH_CYC = rcg_ns_to_cyc(SM_HIGH_NS);
    localparam int unsigned TMR_W = 9;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

    // Control register fields
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_FAST_BIT = 1;
    localparam int unsigned CTRL_CNT_LSB = 8;
    localparam int unsigned CTRL_CH_LSB = 16;

    // Reset values
    localparam logic [7:0] PULSE_COUNT_RST = 8'h09;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Result and channel/device state codes
    typedef enum logic [3:0] {
        RCG_RES_IDLE = 4'h0,
        RCG_RES_NO_INIT = 4'h1,
        RCG_RES_LOCKED = 4'h2,
        RCG_RES_PARAM = 4'h3,
        RCG_RES_SDA_LOW = 4'h4
    } rcg_res_t;

    // Interrupt status bits
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_STUCK_BIT = 1;
    localparam int unsigned IRQ_LOCK_BIT = 2;
    localparam int unsigned IRQ_PARAM_BIT = 3;

    // One recovery request from the register file to the pulse engine
    typedef struct packed {
        logic start;
        logic fast;
        logic [7:0] count;
    } rcg_req_t;

    // Outcome of a recovery sequence
    typedef struct packed {
        logic done;
        logic stuck;
    } rcg_done_t;

    // Pulse engine states
    typedef enum logic [3:0] {
        RCG_ST_IDLE = 4'b0001,
        RCG_ST_LOW = 4'b0010,
        RCG_ST_HIGH = 4'b0100,
        RCG_ST_END = 4'b1000
    } rcg_state_t;

endpackage : rcg_pkg

`default_nettype wire

// File: core/rcg_pulse.sv
/*
 * Pulse engine: drives low-then-high pulses on the clock line until the
 * data line reads high or the pulse budget runs out.
 * Assumes data line input already synchronous to clk_in.
 */
`default_nettype none

module rcg_pulse
    import rcg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Request and result
    input wire rcg_pkg::rcg_req_t req_in,
    output logic busy_out,
    output rcg_pkg::rcg_done_t done_out,
    // Bus lines
    input wire logic sda_in,
    output logic scl_low_out
);
    import rcg_pkg::*;

    typedef struct packed {
        rcg_state_t st;
        logic fast;
        logic [7:0] left;
        logic [TMR_W-1:0] tmr;
        rcg_done_t done;
        logic scl_low;
    } rcg_pst_t;

    rcg_pst_t s_r;
    rcg_pst_t s_nxt;

    // Phase length for the chosen speed mode
    function automatic logic [TMR_W-1:0] phase_len(input logic fast, input logic low);
        int unsigned c;
        if (fast) begin
            c = low ? FM_LOW_CYC : FM_HIGH_CYC;
        end else begin
            c = low ? SM_LOW_CYC : SM_HIGH_CYC;
        end
        return TMR_W'(c - 1);
    endfunction : phase_len

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = '0;
        case (s_r.st)
            RCG_ST_IDLE: begin
                if (req_in.start) begin
                    s_nxt.fast = req_in.fast;
                    s_nxt.left = req_in.count;
                    if (sda_in) begin
                        s_nxt.st = RCG_ST_END;
                    end else begin
                        s_nxt.st = RCG_ST_LOW;
                        s_nxt.scl_low = 1'b1;
                        s_nxt.tmr = phase_len(req_in.fast, 1'b1);
                    end
                end
            end
            RCG_ST_LOW: begin
                if (s_r.tmr != '0) begin
                    s_nxt.tmr = s_r.tmr - 1'b1;
                end else begin
                    s_nxt.st = RCG_ST_HIGH;
                    s_nxt.scl_low = 1'b0;
                    s_nxt.left = s_r.left - 8'h01;
                    s_nxt.tmr = phase_len(s_r.fast, 1'b0);
                end
            end
            RCG_ST_HIGH: begin
                if (s_r.tmr != '0) begin
                    s_nxt.tmr = s_r.tmr - 1'b1;
                end else if (sda_in) begin
                    s_nxt.st = RCG_ST_END;
                end else if (s_r.left == 8'h00) begin
                    s_nxt.st = RCG_ST_IDLE;
                    s_nxt.done = '{done: 1'b1, stuck: 1'b1};
                end else begin
                    s_nxt.st = RCG_ST_LOW;
                    s_nxt.scl_low = 1'b1;
                    s_nxt.tmr = phase_len(s_r.fast, 1'b1);
                end
            end
            RCG_ST_END: begin
                s_nxt.st = RCG_ST_IDLE;
                s_nxt.done = '{done: 1'b1, stuck: 1'b0};
            end
            default: begin
                s_nxt.st = RCG_ST_IDLE;
                s_nxt.scl_low = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '{st: RCG_ST_IDLE, fast: 1'b0, left: 8'h00, tmr: '0,
                     done: '0, scl_low: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign scl_low_out = s_r.scl_low;
    assign busy_out = (s_r.st != RCG_ST_IDLE);
    assign done_out = s_r.done;

endmodule : rcg_pulse

`default_nettype wire

// File: core/rcg_top.sv
/*
 * Bus recovery clock controller: APB register file, request checks,
 * result and state reporting, interrupt and the pulse engine.
 * Assumes APB master on clk_in; bus pins are synchronous inputs.
 */
// Summary of operation
// - Low data: pulse clock until released
// - Eight-bit pulse count, zero invalid
// - Still low after count: stuck error
// - Data high: end, state uninitialized
// - Busy: refuse, report locked, states kept
// - Bad arguments: parameter error, no pulses
// - Released driver but low data: stuck
// - Fast mode: 1.3us low, 0.6us high
// - Standard mode: 4.7us low, 4.0us high
`default_nettype none

module rcg_top
    import rcg_pkg::*;
#(
    parameter int unsigned NUM_CHANNELS = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Other operation in progress on this controller
    input wire logic op_busy_in,
    // Clock line, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    // Data line, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Interrupt
    output logic irq_out
);
    import rcg_pkg::*;

    typedef struct packed {
        logic fast;
        logic [7:0] pulse_count;
        logic [7:0] channel_number;
        rcg_res_t result;
        rcg_res_t chan_state;
        rcg_res_t dev_state;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic scl_oe;
    } rcg_tst_t;

    rcg_tst_t s_r;
    rcg_tst_t s_nxt;
    rcg_req_t req;
    logic eng_busy;
    rcg_done_t eng_done;
    logic eng_scl_low;

    // Register address decode
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
        return a == ref_a;
    endfunction : addr_hit

    wire logic wr_acc = psel_in && penable_in && pwrite_in && !s_r.pready;
    wire logic rd_acc = psel_in && penable_in && !pwrite_in && !s_r.pready;
    wire logic start_wr = wr_acc && addr_hit(paddr_in, ADDR_CTRL)
                          && pwdata_in[CTRL_START_BIT];
    wire logic [7:0] wr_cnt = pwdata_in[CTRL_CNT_LSB +: 8];
    wire logic [7:0] wr_ch = pwdata_in[CTRL_CH_LSB +: 8];

    wire logic req_locked = start_wr && (eng_busy || op_busy_in);
    wire logic req_bad = start_wr && !req_locked
                         && ((wr_cnt == 8'h00) || (32'(wr_ch) >= NUM_CHANNELS));

    // Request to the pulse engine
    always_comb begin
        req.start = start_wr && !req_locked && !req_bad;
        req.fast = pwdata_in[CTRL_FAST_BIT];
        req.count = wr_cnt;
    end

    rcg_pulse u_pulse (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .req_in(req),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .sda_in(sda_in),
        .scl_low_out(eng_scl_low)
    );

    // Register file, result and interrupt logic
    always_comb begin
        logic [3:0] ev;
        ev = 4'h0;
        s_nxt = s_r;
        s_nxt.pready = (psel_in && penable_in && !s_r.pready);
        s_nxt.pslverr = 1'b0;
        s_nxt.scl_oe = eng_scl_low;
        if (wr_acc) begin
            if (addr_hit(paddr_in, ADDR_CTRL)) begin
                s_nxt.fast = pwdata_in[CTRL_FAST_BIT];
                s_nxt.pulse_count = wr_cnt;
                s_nxt.channel_number = wr_ch;
            end else if (addr_hit(paddr_in, ADDR_IRQ_MASK)) begin
                s_nxt.irq_mask = pwdata_in[3:0];
            end else if (!addr_hit(paddr_in, ADDR_STATUS)
                         && !addr_hit(paddr_in, ADDR_RESULT)
                         && !addr_hit(paddr_in, ADDR_IRQ_STAT)) begin
                s_nxt.pslverr = 1'b1;
            end
        end
        if (req_locked) begin
            s_nxt.result = RCG_RES_LOCKED;
            ev[IRQ_LOCK_BIT] = 1'b1;
        end
        if (req_bad) begin
            s_nxt.result = RCG_RES_PARAM;
            ev[IRQ_PARAM_BIT] = 1'b1;
        end
        if (req.start) begin
            s_nxt.result = RCG_RES_IDLE;
        end
        if (eng_done.done) begin
            if (eng_done.stuck) begin
                s_nxt.result = RCG_RES_SDA_LOW;
                s_nxt.chan_state = RCG_RES_SDA_LOW;
                s_nxt.dev_state = RCG_RES_SDA_LOW;
                ev[IRQ_STUCK_BIT] = 1'b1;
            end else begin
                s_nxt.result = RCG_RES_NO_INIT;
                s_nxt.chan_state = RCG_RES_NO_INIT;
                s_nxt.dev_state = RCG_RES_NO_INIT;
                ev[IRQ_DONE_BIT] = 1'b1;
            end
        end
        s_nxt.prdata = 32'h0000_0000;
        if (rd_acc) begin
            if (addr_hit(paddr_in, ADDR_CTRL)) begin
                s_nxt.prdata = {8'h00, s_r.channel_number, s_r.pulse_count,
                                6'h00, s_r.fast, 1'b0};
            end else if (addr_hit(paddr_in, ADDR_STATUS)) begin
                s_nxt.prdata = {20'h00000, s_r.dev_state, s_r.chan_state,
                                sda_in, scl_in, eng_scl_low, eng_busy};
            end else if (addr_hit(paddr_in, ADDR_RESULT)) begin
                s_nxt.prdata = {28'h0000000, s_r.result};
            end else if (addr_hit(paddr_in, ADDR_IRQ_STAT)) begin
                s_nxt.prdata = {28'h0000000, s_r.irq_stat};
                // Read clears, a new event in the same cycle survives
                s_nxt.irq_stat = 4'h0;
            end else if (addr_hit(paddr_in, ADDR_IRQ_MASK)) begin
                s_nxt.prdata = {28'h0000000, s_r.irq_mask};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    // State register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '{fast: 1'b0, pulse_count: PULSE_COUNT_RST, channel_number: 8'h00,
                     result: RCG_RES_IDLE, chan_state: RCG_RES_NO_INIT,
                     dev_state: RCG_RES_NO_INIT, irq_stat: 4'h0, irq_mask: IRQ_MASK_RST,
                     prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0, irq: 1'b0,
                     scl_oe: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops or tied to zero; open drain drives low only
    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign irq_out = s_r.irq;
    assign scl_out = 1'b0;
    assign scl_oe_out = s_r.scl_oe;
    assign sda_out = 1'b0;
    assign sda_oe_out = 1'b0;

endmodule : rcg_top

`default_nettype wire

// File: bench/rcg_top_properties.sv
/*
 * Port checker for the recovery clock controller.
 * Assumes it is bound to rcg_top with one clock domain on clk_in.
 */
`default_nettype none

module rcg_chk
    import rcg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Watched ports
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out
);
    logic [8:0] drv_r;
    logic [8:0] rel_r;

    // Lengths of the driven and released clock phases
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            drv_r <= 9'h0;
            rel_r <= 9'h1ff;
        end else begin
            drv_r <= scl_oe_out ? ((drv_r == 9'h1ff) ? drv_r : drv_r + 9'h1) : 9'h0;
            rel_r <= scl_oe_out ? 9'h0 : ((rel_r == 9'h1ff) ? rel_r : rel_r + 9'h1);
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_drive_start;
        !scl_oe_out ##1 scl_oe_out;
    endsequence
    sequence s_ready_once;
        pready_out ##1 !pready_out;
    endsequence

    property p_low_min;
        $fell(scl_oe_out) |-> drv_r >= 9'(FM_LOW_CYC);
    endproperty
    property p_high_min;
        $rose(scl_oe_out) |-> rel_r >= 9'(FM_HIGH_CYC);
    endproperty
    property p_low_max;
        scl_oe_out |-> drv_r < 9'(SM_LOW_CYC);
    endproperty
    property p_hold;
        s_drive_start |=> scl_oe_out [*8];
    endproperty
    property p_start_low;
        $rose(scl_oe_out) |-> !sda_in;
    endproperty
    property p_data_free;
        !sda_oe_out && !sda_out && !scl_out;
    endproperty
    property p_ready;
        psel_in && penable_in && !pready_out |=> s_ready_once;
    endproperty
    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    property p_rdata_idle;
        !pready_out |-> prdata_out == 32'h0;
    endproperty

    a_low_min: assert property (p_low_min) else $error("clock low phase too short");
    a_high_min: assert property (p_high_min) else $error("clock high phase too short");
    a_low_max: assert property (p_low_max) else $error("clock held low too long");
    a_hold: assert property (p_hold) else $error("clock pulse cut short");
    a_start_low: assert property (p_start_low) else $error("pulse with data free");
    a_data_free: assert property (p_data_free) else $error("line driver active");
    a_ready: assert property (p_ready) else $error("ready not one wait state");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
endmodule : rcg_chk

bind rcg_top rcg_chk chk_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .sda_in(sda_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

`default_nettype wire

// File: bench/rcg_slave_model.sv
/*
 * Bus slave out of step, holding the data line low.
 * Assumes the clock line level comes from the bench; pull-up on data.
 */
`default_nettype none

module rcg_slave_model (
    // Clock and lines
    input wire logic clk_in,
    input wire logic scl_in,
    // Control
    input wire logic arm_in,
    input wire logic [7:0] hold_in,
    // Outputs
    output logic sda_low_out,
    output logic [7:0] pulses_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_r;

    // held low after desync
    // Counts clock rises, frees data after hold_in rises, 8'h00 never held
    always_ff @(posedge clk_in) begin
        prev_r <= scl_in;
        if (arm_in) begin
            pulses_out <= 8'h00;
            sda_low_out <= (hold_in != 8'h00);
        end else if (!prev_r && scl_in) begin
            pulses_out <= pulses_out + 8'h01;
            if (pulses_out + 8'h01 == hold_in)
                sda_low_out <= 1'b0;
        end
    end
endmodule : rcg_slave_model

`default_nettype wire

// File: bench/rcg_top_tb.sv
/*
 * Testbench: APB register tasks, recovery runs against a stuck slave.
 * Assumes pull-ups on both lines and the bound port checker.
 */
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %0t: got %h exp %h", $time, g, e); end end

module rcg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rcg_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0;
    logic op_busy_in = 1'b0;
    logic arm = 1'b1;
    logic [7:0] hold = 8'h00;
    logic [31:0] prdata_out, q;
    logic pready_out, pslverr_out, scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, e;
    logic sda_low;
    logic [7:0] pulses;
    int err_total = 0;
    int comparisons = 0;
    // Open-drain lines with pull-ups
    wire logic scl_line = !scl_oe_out;
    wire logic sda_line = !sda_low && !sda_oe_out;

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    rcg_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .op_busy_in(op_busy_in), .scl_in(scl_line),
        .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .irq_out(irq_out));
    rcg_slave_model slave_u (.clk_in(clk_in), .scl_in(scl_line), .arm_in(arm),
        .hold_in(hold), .sda_low_out(sda_low), .pulses_out(pulses));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // One APB transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask : rd

    // Arm slave, request recovery, wait for idle, check result and pulses
    task automatic run(input logic f, input logic [7:0] cnt, input logic [7:0] ch,
        input logic [7:0] hld, input logic [3:0] res, input logic [7:0] np);
        int n;
        n = 0;
        @(posedge clk_in);
        hold <= hld;
        arm <= 1'b1;
        @(posedge clk_in);
        arm <= 1'b0;
        apb(1'b1, ADDR_CTRL, {8'h00, ch, cnt, 6'h00, f, 1'b1});
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            err_total++;
            give_verdict();
        end
        rd(ADDR_RESULT, {28'h0, res});
        `CHK(pulses, np)
    endtask : run

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0900);
        rd(ADDR_STATUS, 32'h0000_011c);
        rd(ADDR_RESULT, 32'h0);
        rd(ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'hf);
        run(1'b1, 8'h09, 8'h00, 8'h00, 4'h1, 8'h00);
        `CHK(irq_out, 1'b1)
        rd(ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_in);
        `CHK(irq_out, 1'b0)
        run(1'b1, 8'h09, 8'h01, 8'h02, 4'h1, 8'h02);
        rd(ADDR_STATUS, 32'h0000_011c);
        rd(ADDR_RESULT, 32'h1);
        rd(ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        run(1'b0, 8'h03, 8'h00, 8'hff, 4'h4, 8'h03);
        rd(ADDR_STATUS, 32'h0000_0444);
        `CHK(irq_out, 1'b0)
        rd(ADDR_IRQ_STAT, 32'h2);
        run(1'b1, 8'h00, 8'h00, 8'hff, 4'h3, 8'h00);
        run(1'b1, 8'h09, 8'h02, 8'hff, 4'h3, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0444);
        op_busy_in <= 1'b1;
        run(1'b1, 8'h09, 8'h00, 8'hff, 4'h2, 8'h00);
        op_busy_in <= 1'b0;
        rd(ADDR_STATUS, 32'h0000_0444);
        rd(ADDR_IRQ_STAT, 32'hc);
        rd(12'h014, 32'h0);
        `CHK(e, 1'b1)
        give_verdict();
    end
endmodule : rcg_top_tb

`default_nettype wire
